// ---- logic/mps_pkg.sv ----
/*
 Constants shared by the parameter access slave: frame layout, tag map,
 function masks, exception codes, timing and state encodings.
 Assumes a byte-oriented link with frames delimited by the receiver.
*/
package mps_pkg;
   // frame layout, byte positions from the start of a frame
   localparam int unsigned POS_ADDR = 0;
   localparam int unsigned POS_FN = 1;
   localparam int unsigned POS_BC = 2;
   localparam int unsigned POS_REF = 3;
   localparam int unsigned POS_FILE = 4;
   localparam int unsigned POS_TAG = 6;
   localparam int unsigned POS_CNT = 8;
   localparam int unsigned POS_DATA = 10;
   localparam int unsigned POS_SUB = 3;
   localparam int unsigned POS_RREF = 4;
   localparam int unsigned POS_RDATA = 5;
   // frame lengths; received ones include the two check bytes
   localparam int unsigned MIN_RX_LEN = 4;
   localparam int unsigned WR_RX_LEN = 16;
   localparam int unsigned RD_RX_LEN = 12;
   localparam int unsigned ECHO_LEN = 14;
   localparam int unsigned RD_RSP_LEN = 9;
   localparam int unsigned EXC_LEN = 3;
   localparam int unsigned BUF_DEPTH_DEF = 16;
   // field values
   localparam logic [7:0] FN_READ = 8'h14;
   localparam logic [7:0] FN_WRITE = 8'h15;
   localparam logic [7:0] FN_LIMIT = 8'h20;
   localparam logic [7:0] WR_BC = 8'h0B;
   localparam logic [7:0] RD_BC = 8'h07;
   localparam logic [7:0] RD_RSP_BC = 8'h06;
   localparam logic [7:0] SUB_LEN = 8'h05;
   localparam logic [7:0] REF_TYPE = 8'h06;
   localparam logic [7:0] FILE_HI = 8'h00;
   localparam logic [7:0] FILE_LO = 8'h03;
   localparam logic [7:0] TAG_HI = 8'h00;
   localparam logic [7:0] CNT_HI = 8'h00;
   localparam logic [7:0] CNT_LO = 8'h02;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EX_NONE = 8'h00;
   localparam logic [7:0] EX_FUNC = 8'h01;
   localparam logic [7:0] EX_ADDR = 8'h02;
   localparam logic [7:0] EX_DATA = 8'h03;
   // parameter tags
   localparam logic [7:0] TAG_SUMMARY = 8'h7A;
   localparam logic [7:0] TAG_IN1 = 8'h7B;
   localparam logic [7:0] TAG_IN2 = 8'h7C;
   localparam logic [7:0] TAG_OVERRIDE = 8'h7D;
   localparam logic [7:0] TAG_KIND = 8'h9D;
   localparam logic [7:0] TAG_REV = 8'hA7;
   localparam logic [7:0] TAG_OPTIONS = 8'hB9;
   localparam logic [7:0] ANALOG_LO = 8'h01;
   localparam logic [7:0] ANALOG_HI = 8'h74;
   localparam logic [7:0] DIGITAL_LO = 8'h80;
   localparam logic [7:0] DIGITAL_HI = 8'hFA;
   localparam logic [15:0] REV_LIMIT = 16'h00FF;
   // accepted function codes, one bit per code
   localparam logic [31:0] WIRE_FN_MASK = 32'h0033005E;
   localparam logic [31:0] IR_FN_MASK = 32'h00300000;
   // check sequence
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   // timing
   localparam int unsigned CLK_NS = 4;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_NS;
   localparam int unsigned MS_PER_SEC = 1000;
   typedef enum logic [3:0] {
      ST_RX = 4'b0001,
      ST_CHECK = 4'b0010,
      ST_NVM = 4'b0100,
      ST_SEND = 4'b1000
   } mps_state_t;
   typedef enum logic [2:0] {
      MD_MONITOR = 3'b001,
      MD_SLAVE = 3'b010,
      MD_EMERG = 3'b100
   } mps_mode_t;
   localparam int unsigned MD_MONITOR_BIT = 0;
   localparam int unsigned MD_SLAVE_BIT = 1;
   localparam int unsigned MD_EMERG_BIT = 2;
endpackage

// ---- logic/mps_crc_step.sv ----
/*
 One byte step of the reflected 16-bit frame check.
 Purely combinational; the caller holds the running value in a register.
*/
`timescale 1ns/1ps
module mps_crc_step (
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data,
   output logic [15:0] crc_out
);
   import mps_pkg::*;
   always_comb begin
      logic [15:0] c;
      c = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule // mps_crc_step

// ---- logic/mps_param_slave.sv ----
/*
 Parameter access slave: takes request frames byte by byte, checks them,
 serves tagged reads and writes, echoes writes and drives the mode logic.
 Assumes a framer that marks the gap after a frame with rx_end and an
 outside store that commits non-volatile writes and reports completion.
*/
// Notes on behaviour
// - an accepted write is answered by echoing its bytes plus a fresh check.
// - writes to the three control data tags get an error answer.
// - analog tags 01..74 are committed first, answer comes only after.
// - setpoint override tag 7D is volatile, honoured only in slave mode.
// - digital tags 80..FA start their commit on message receipt.
// - infrared accepts only 20 and 21; wired ports accept the wider set.
// - with shed timer on, an accepted write in monitor mode enters slave mode, keypad locked.
// - slave mode with silent link until timeout returns to monitor mode, flagging a shed event.
// - manual key in slave mode enters emergency manual mode.
// - shed timer off keeps the device in monitor mode.
// - option status reads as 0..255, one bit per option.
// - firmware kind and revision are read-only; revision stays below 255.
// - a write carrying more than one parameter is invalid.
// - the tag field high byte must be zero; low byte is the tag.
`timescale 1ns/1ps
module mps_param_slave #(
   parameter int unsigned MS_CYCLES = mps_pkg::MS_CYCLES_DEF,
   parameter int unsigned BUF_DEPTH = mps_pkg::BUF_DEPTH_DEF,
   parameter logic [15:0] KIND_CODE = 16'h0001, // arbitrary identity value
   parameter logic [15:0] REVISION = 16'h0001
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic ir_port,
   input wire logic [7:0] slave_address,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic [31:0] summary_value,
   input wire logic [31:0] input1_value,
   input wire logic [31:0] input2_value,
   input wire logic [7:0] option_bits,
   input wire logic [7:0] shed_seconds,
   input wire logic manual_automatic_key,
   output logic nvm_wr_req,
   output logic [7:0] nvm_tag,
   output logic [31:0] nvm_data,
   input wire logic nvm_done,
   output logic fwd_valid,
   output logic [7:0] fwd_function,
   output logic [31:0] override_value,
   output logic override_active,
   output logic monitor_mode,
   output logic slave_mode,
   output logic emergency_manual,
   output logic shed_event
);
   import mps_pkg::*;
   localparam int unsigned BW = $clog2(BUF_DEPTH);
   localparam int unsigned MW = $clog2(MS_CYCLES + 1);
   localparam int unsigned SW = $clog2(MS_PER_SEC + 1);

   if (BUF_DEPTH < WR_RX_LEN || (1 << BW) != BUF_DEPTH) begin : g_chk_buf
      $error("buffer depth must be a power of two holding a write frame");
   end
   if (MS_CYCLES < 1) begin : g_chk_ms
      $error("millisecond divider must be at least one cycle");
   end
   if (REVISION >= REV_LIMIT) begin : g_chk_rev
      $error("revision must stay below 255");
   end

   logic [1:0] rst_sync;
   logic rst_n;
   mps_state_t st;
   mps_mode_t mode;
   mps_mode_t next_mode;
   logic [7:0] fbuf [BUF_DEPTH];
   logic [BW:0] rx_cnt;
   logic [BW:0] len_q;
   logic rx_ovf;
   logic ir_q;
   logic [15:0] crc_rx;
   logic [15:0] crc_rx_next;
   logic [15:0] crc_tx;
   logic [15:0] crc_tx_next;
   logic [BW:0] tx_idx;
   logic [BW:0] tx_len;
   logic [MW-1:0] ms_cnt;
   logic [SW-1:0] sec_ms;
   logic ms_tick;
   logic sec_tick;
   logic [7:0] shed_sec;
   logic shed_hit;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // frame acceptance
   logic frame_good;
   logic crc_bad;
   assign crc_bad = (st == ST_RX) && rx_end && (crc_rx != 16'h0000);
   assign frame_good = (st == ST_RX) && rx_end && (crc_rx == 16'h0000) && !rx_ovf &&
      (rx_cnt >= (BW+1)'(MIN_RX_LEN)) && (fbuf[POS_ADDR] == slave_address);

   // request decode, valid while st is ST_CHECK
   logic [7:0] fn;
   logic [7:0] tag;
   logic fn_ok;
   logic hdr_ok;
   logic wr_ok;
   logic rd_ok;
   logic is_ro;
   logic is_analog;
   logic is_ovr;
   logic is_dig;
   logic rd_hit;
   logic [31:0] rd_val;
   logic [7:0] exc;
   logic fwd;
   logic wr_accept;
   logic [31:0] wr_val;
   assign fn = fbuf[POS_FN];
   assign tag = fbuf[POS_TAG+1];
   assign wr_val = {fbuf[POS_DATA], fbuf[POS_DATA+1], fbuf[POS_DATA+2], fbuf[POS_DATA+3]};
   assign fn_ok = (fn < FN_LIMIT) && (ir_q ? IR_FN_MASK[fn[4:0]] : WIRE_FN_MASK[fn[4:0]]);
   assign hdr_ok = (fbuf[POS_REF] == REF_TYPE) && (fbuf[POS_FILE] == FILE_HI) &&
      (fbuf[POS_FILE+1] == FILE_LO) && (fbuf[POS_TAG] == TAG_HI) &&
      (fbuf[POS_CNT] == CNT_HI) && (fbuf[POS_CNT+1] == CNT_LO);
   // one parameter per write: any other length or count is refused
   assign wr_ok = (fn == FN_WRITE) && (len_q == (BW+1)'(WR_RX_LEN)) && (fbuf[POS_BC] == WR_BC) && hdr_ok;
   assign rd_ok = (fn == FN_READ) && (len_q == (BW+1)'(RD_RX_LEN)) && (fbuf[POS_BC] == RD_BC) && hdr_ok;
   assign is_ro = (tag == TAG_SUMMARY) || (tag == TAG_IN1) || (tag == TAG_IN2) ||
      (tag == TAG_KIND) || (tag == TAG_REV) || (tag == TAG_OPTIONS);
   assign is_analog = (tag >= ANALOG_LO) && (tag <= ANALOG_HI);
   assign is_ovr = (tag == TAG_OVERRIDE);
   assign is_dig = (tag >= DIGITAL_LO) && (tag <= DIGITAL_HI) && !is_ro;

   always_comb begin
      rd_hit = 1'b1;
      unique case (tag)
         TAG_SUMMARY: rd_val = summary_value;
         TAG_IN1: rd_val = input1_value;
         TAG_IN2: rd_val = input2_value;
         TAG_OVERRIDE: rd_val = override_value;
         TAG_KIND: rd_val = {16'h0000, KIND_CODE};
         TAG_REV: rd_val = {16'h0000, REVISION};
         TAG_OPTIONS: rd_val = {24'h000000, option_bits};
         default: begin
            rd_val = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      exc = EX_NONE;
      if (!fn_ok) begin
         exc = EX_FUNC;
      end else if (fn == FN_WRITE) begin
         if (!wr_ok) begin
            exc = EX_DATA;
         end else if (is_ro || !(is_analog || is_ovr || is_dig)) begin
            exc = EX_ADDR;
         end
      end else if (fn == FN_READ) begin
         if (!rd_ok) begin
            exc = EX_DATA;
         end else if (!rd_hit) begin
            exc = EX_ADDR;
         end
      end
   end
   assign fwd = fn_ok && (fn != FN_READ) && (fn != FN_WRITE);
   assign wr_accept = (st == ST_CHECK) && (exc == EX_NONE) && (fn == FN_WRITE);

   logic send_step;
   logic send_done;
   assign send_step = (st == ST_SEND) && (!tx_valid || tx_ready);
   assign send_done = send_step && (tx_idx == tx_len + (BW+1)'(2));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RX;
      end else begin
         unique case (st)
            ST_RX: if (frame_good) st <= ST_CHECK;
            ST_CHECK: begin
               if (fwd) begin
                  st <= ST_RX;
               end else if (wr_accept && is_analog) begin
                  st <= ST_NVM;
               end else begin
                  st <= ST_SEND;
               end
            end
            ST_NVM: if (nvm_done) st <= ST_SEND;
            ST_SEND: if (send_done) st <= ST_RX;
         endcase
      end
   end

   // receive side; bytes outside ST_RX are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt <= '0;
         rx_ovf <= 1'b0;
         crc_rx <= CRC_INIT;
         len_q <= '0;
         ir_q <= 1'b0;
      end else if (st != ST_RX || rx_end) begin
         rx_cnt <= '0;
         rx_ovf <= 1'b0;
         crc_rx <= CRC_INIT;
         if (st == ST_RX) begin
            len_q <= rx_cnt;
            ir_q <= ir_port;
         end
      end else if (rx_valid) begin
         crc_rx <= crc_rx_next;
         if (rx_cnt == (BW+1)'(BUF_DEPTH)) begin
            rx_ovf <= 1'b1;
         end else begin
            rx_cnt <= rx_cnt + (BW+1)'(1);
         end
      end
   end

   mps_crc_step u_crc_rx (
      .crc_in(crc_rx),
      .data(rx_data),
      .crc_out(crc_rx_next)
   );

   // one buffer holds the request and is rewritten in place into the answer
   always_ff @(posedge clk) begin
      if (st == ST_RX && rx_valid && !rx_end && rx_cnt < (BW+1)'(BUF_DEPTH)) begin
         fbuf[rx_cnt[BW-1:0]] <= rx_data;
      end else if (st == ST_CHECK) begin
         if (exc != EX_NONE) begin
            fbuf[POS_FN] <= fn | EXC_FLAG;
            fbuf[POS_BC] <= exc;
         end else if (fn == FN_READ) begin
            fbuf[POS_BC] <= RD_RSP_BC;
            fbuf[POS_SUB] <= SUB_LEN;
            fbuf[POS_RREF] <= REF_TYPE;
            fbuf[POS_RDATA] <= rd_val[31:24];
            fbuf[POS_RDATA+1] <= rd_val[23:16];
            fbuf[POS_RDATA+2] <= rd_val[15:8];
            fbuf[POS_RDATA+3] <= rd_val[7:0];
         end
      end
   end

   // transmit: buffer bytes, then check low byte, then high byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         tx_data <= 8'h00;
         tx_idx <= '0;
         tx_len <= '0;
         crc_tx <= CRC_INIT;
      end else if (st == ST_CHECK) begin
         tx_idx <= '0;
         crc_tx <= CRC_INIT;
         if (exc != EX_NONE) begin
            tx_len <= (BW+1)'(EXC_LEN);
         end else if (fn == FN_READ) begin
            tx_len <= (BW+1)'(RD_RSP_LEN);
         end else begin
            tx_len <= (BW+1)'(ECHO_LEN);
         end
      end else if (send_step) begin
         if (tx_idx < tx_len) begin
            tx_data <= fbuf[tx_idx[BW-1:0]];
            crc_tx <= crc_tx_next;
            tx_valid <= 1'b1;
         end else if (tx_idx == tx_len) begin
            tx_data <= crc_tx[7:0];
         end else if (tx_idx == tx_len + (BW+1)'(1)) begin
            tx_data <= crc_tx[15:8];
            tx_last <= 1'b1;
         end else begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
         end
         if (!send_done) begin
            tx_idx <= tx_idx + (BW+1)'(1);
         end
      end
   end

   mps_crc_step u_crc_tx (
      .crc_in(crc_tx),
      .data(fbuf[tx_idx[BW-1:0]]),
      .crc_out(crc_tx_next)
   );

   // store requests; the override never touches non-volatile storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_wr_req <= 1'b0;
         nvm_tag <= 8'h00;
         nvm_data <= 32'h00000000;
         override_value <= 32'h00000000;
         fwd_valid <= 1'b0;
         fwd_function <= 8'h00;
      end else begin
         nvm_wr_req <= wr_accept && (is_analog || is_dig);
         fwd_valid <= (st == ST_CHECK) && fwd;
         if (wr_accept && (is_analog || is_dig)) begin
            nvm_tag <= tag;
            nvm_data <= wr_val;
         end
         if (wr_accept && is_ovr) begin
            override_value <= wr_val;
         end
         if (st == ST_CHECK && fwd) begin
            fwd_function <= fn;
         end
      end
   end

   // millisecond and second enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt <= '0;
         sec_ms <= '0;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else if (frame_good || mode != MD_SLAVE) begin
         // free-running prescaler would shed up to a second early
         ms_cnt <= '0;
         sec_ms <= '0;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == MW'(MS_CYCLES - 1));
         ms_cnt <= (ms_cnt == MW'(MS_CYCLES - 1)) ? '0 : ms_cnt + MW'(1);
         sec_tick <= ms_tick && (sec_ms == SW'(MS_PER_SEC - 1));
         if (ms_tick) begin
            sec_ms <= (sec_ms == SW'(MS_PER_SEC - 1)) ? '0 : sec_ms + SW'(1);
         end
      end
   end

   // shed timer restarts on every good frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shed_sec <= 8'h00;
      end else if (frame_good || mode != MD_SLAVE) begin
         shed_sec <= 8'h00;
      end else if (sec_tick && shed_sec != 8'hFF) begin
         shed_sec <= shed_sec + 8'h01;
      end
   end

   logic shed_en;
   assign shed_en = (shed_seconds != 8'h00);
   always_comb begin
      next_mode = mode;
      shed_hit = 1'b0;
      unique case (mode)
         MD_MONITOR: if (shed_en && wr_accept) next_mode = MD_SLAVE;
         MD_SLAVE: begin
            if (!shed_en) begin
               next_mode = MD_MONITOR;
            end else if (manual_automatic_key) begin
               next_mode = MD_EMERG;
            end else if (shed_sec >= shed_seconds) begin
               next_mode = MD_MONITOR;
               shed_hit = 1'b1;
            end
         end
         MD_EMERG: if (manual_automatic_key || !shed_en) next_mode = MD_MONITOR;
         default: next_mode = MD_MONITOR;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MD_MONITOR;
         shed_event <= 1'b0;
         override_active <= 1'b0;
      end else begin
         mode <= next_mode;
         shed_event <= shed_hit;
         override_active <= (next_mode == MD_SLAVE) && (override_active || (wr_accept && is_ovr));
      end
   end
   assign monitor_mode = mode[MD_MONITOR_BIT];
   assign slave_mode = mode[MD_SLAVE_BIT];
   assign emergency_manual = mode[MD_EMERG_BIT];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_crc_drop: assert property (crc_bad |=> st == ST_RX ##1 !tx_valid)
      else $error("bad check frame was not dropped");
   a_write_echo: assert property (wr_accept |=> tx_len == (BW+1)'(ECHO_LEN) && (st == ST_SEND || st == ST_NVM))
      else $error("accepted write not set up for an echo");
   a_ro_reject: assert property (st == ST_CHECK && fn_ok && wr_ok && is_ro
      |=> fbuf[POS_FN] == (FN_WRITE | EXC_FLAG) && !nvm_wr_req && tx_len == (BW+1)'(EXC_LEN))
      else $error("read-only write not refused");
   a_analog_order: assert property (wr_accept && is_analog |=> nvm_wr_req && st == ST_NVM)
      else $error("analog write did not wait for commit");
   a_nvm_quiet: assert property (st == ST_NVM |-> !tx_valid)
      else $error("answer sent before commit finished");
   a_ovr_volatile: assert property (wr_accept && is_ovr |=> !nvm_wr_req && override_value == $past(wr_val))
      else $error("override reached non-volatile store");
   a_digital_now: assert property (wr_accept && is_dig |=> nvm_wr_req && st == ST_SEND ##1 !nvm_wr_req)
      else $error("digital commit not issued at receipt");
   a_ir_funcs: assert property (st == ST_CHECK && ir_q && fn != FN_READ && fn != FN_WRITE
      |=> fbuf[POS_BC] == EX_FUNC && !fwd_valid)
      else $error("infrared accepted a wired-only function");
   a_slave_entry: assert property (mode == MD_MONITOR && shed_en && wr_accept |=> slave_mode && !monitor_mode)
      else $error("write did not enter slave mode");
   a_shed_exit: assert property (mode == MD_SLAVE && shed_en && !manual_automatic_key && shed_sec >= shed_seconds
      |=> shed_event && monitor_mode && !override_active)
      else $error("shed timeout did not leave slave mode");
   a_emerg_key: assert property (mode == MD_SLAVE && shed_en && manual_automatic_key |=> emergency_manual)
      else $error("manual key did not enter emergency manual");
   a_monitor_only: assert property (!shed_en |=> !slave_mode && !emergency_manual)
      else $error("slave mode with shed timer off");
   a_multi_param: assert property (st == ST_CHECK && fn_ok && fn == FN_WRITE && len_q != (BW+1)'(WR_RX_LEN)
      |=> fbuf[POS_BC] == EX_DATA)
      else $error("multi-parameter write not refused");
endmodule // mps_param_slave

// ---- dv/mps_host_model.sv ----
/*
 Host master model: frames requests with check bytes, takes the answers.
 Assumes one bench process calls its tasks.
*/
`timescale 1ns/1ps
module mps_host_model (
   input wire logic clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready
);
   import mps_pkg::*;
   logic [7:0] rsp [$];
   time t0;
   initial begin
      {rx_valid, rx_data, rx_end, tx_ready} = 11'h000;
   end
   function automatic logic [15:0] crc(input logic [7:0] f [$]);
      crc = CRC_INIT;
      foreach (f[i]) begin
         crc ^= {8'h00, f[i]};
         repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
      end
   endfunction
   // frame sent as given, check low byte first
   task automatic send(input logic [7:0] f [$], input logic bad);
      logic [15:0] c;
      c = crc(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         // slow host: random idle cycles, idle data never repeats the byte
         repeat ($urandom_range(0, 1)) begin
            @(posedge clk);
            #1 rx_valid = 1'h0;
            rx_data = ~rx_data;
         end
         @(posedge clk);
         #1 rx_valid = 1'h1;
         rx_data = f[i];
      end
      @(posedge clk);
      #1 rx_valid = 1'h0;
      rx_data = ~rx_data;
      rx_end = 1'h1;
      @(posedge clk);
      #1 rx_end = 1'h0;
   endtask
   // stalls at random; a byte counts where ready and valid meet
   task automatic collect(input int lim);
      rsp.delete();
      repeat (lim) begin
         @(posedge clk);
         #1 tx_ready = $urandom_range(0, 2) != 0;
         #2 if (tx_valid === 1'h1 && tx_ready) begin
            if (rsp.size() == 0) t0 = $time;
            rsp.push_back(tx_data);
            if (tx_last === 1'h1) break;
         end
      end
      @(posedge clk);
      #1 tx_ready = 1'h0;
   endtask
endmodule // mps_host_model

// ---- dv/tb_top.sv ----
/*
 Self-checking bench for the parameter access slave.
 Assumes the host model on the link; the commit store is modelled here.
*/
`timescale 1ns/1ps
module tb_top;
   import mps_pkg::*;
   typedef logic [7:0] mps_bq_t [$];
   localparam logic [15:0] KIND = 16'h0005; // arbitrary identity value
   localparam logic [15:0] REV = 16'h00A3;
   localparam int MS = 4;
   localparam logic [7:0] DT [2] = '{DIGITAL_LO, DIGITAL_HI};
   localparam logic [7:0] RO [6] = '{TAG_SUMMARY, TAG_IN1, TAG_IN2, TAG_KIND, TAG_REV, TAG_OPTIONS};
   localparam logic [7:0] WF [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h10, 8'h11};
   logic clk = 1'h0, resetn = 1'h0, ir_port, manual_automatic_key, nvm_done, rx_valid, rx_end, tx_valid, tx_last;
   logic tx_ready, nvm_wr_req, fwd_valid, override_active, monitor_mode, slave_mode, emergency_manual, shed_event;
   logic [7:0] rx_data, slave_address, tx_data, option_bits, shed_seconds, nvm_tag, fwd_function, ntag, lfn;
   logic [31:0] summary_value, input1_value, input2_value, nvm_data, override_value, ndat, d;
   int err_count, n_tests, hits, sheds, wt, h;
   time done_t;
   mps_bq_t q;
   mps_param_slave #(.MS_CYCLES(MS), .KIND_CODE(KIND), .REVISION(REV)) dut (.clk, .resetn, .rx_valid, .rx_data,
      .rx_end, .ir_port, .slave_address, .tx_valid, .tx_data, .tx_last, .tx_ready, .summary_value, .input1_value,
      .input2_value, .option_bits, .shed_seconds, .manual_automatic_key, .nvm_wr_req, .nvm_tag, .nvm_data,
      .nvm_done, .fwd_valid, .fwd_function, .override_value, .override_active, .monitor_mode, .slave_mode,
      .emergency_manual, .shed_event);
   mps_host_model host (.clk, .rx_valid, .rx_data, .rx_end, .tx_valid, .tx_data, .tx_last, .tx_ready);
   always #2 clk = ~clk;
   // commit store: slow on purpose so an early answer shows
   always @(posedge clk) begin
      if (nvm_wr_req === 1'h1) begin
         hits <= hits + 1;
         ntag <= nvm_tag;
         ndat <= nvm_data;
         wt <= 9;
      end
      else if (wt > 0) wt <= wt - 1;
      nvm_done <= #1 wt == 1;
      if (wt == 1) done_t <= $time;
      if (fwd_valid === 1'h1) lfn <= fwd_function;
      if (shed_event === 1'h1) sheds <= sheds + 1;
   end
   task automatic print_verdict();
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic mps_bq_t wr(input logic [7:0] t, input logic [31:0] v);
      return '{slave_address, FN_WRITE, WR_BC, REF_TYPE, FILE_HI, FILE_LO, TAG_HI, t, CNT_HI, CNT_LO,
         v[31:24], v[23:16], v[15:8], v[7:0]};
   endfunction
   function automatic mps_bq_t rd(input logic [7:0] t);
      return '{slave_address, FN_READ, RD_BC, REF_TYPE, FILE_HI, FILE_LO, TAG_HI, t, CNT_HI, CNT_LO};
   endfunction
   function automatic mps_bq_t rr(input logic [31:0] v);
      return '{slave_address, FN_READ, RD_RSP_BC, SUB_LEN, REF_TYPE, v[31:24], v[23:16], v[15:8], v[7:0]};
   endfunction
   function automatic mps_bq_t ex(input logic [7:0] f, input logic [7:0] c);
      return '{slave_address, f | EXC_FLAG, c};
   endfunction
   task automatic xfer(input mps_bq_t f, input mps_bq_t e, input logic bad);
      logic [15:0] c;
      host.send(f, bad);
      host.collect(e.size() ? 200 : 40);
      c = host.crc(e);
      if (e.size()) e = {e, c[7:0], c[15:8]};
      chk(host.rsp.size(), e.size());
      foreach (e[i]) if (i < host.rsp.size()) chk(host.rsp[i], e[i]);
      // spacing scaled down with the timer: 20 ms reads, 200 ms writes
      repeat ((f[1] == FN_WRITE ? 200 : 20) * MS) @(posedge clk);
      #1;
   endtask
   initial begin
      void'($urandom(95));
      {ir_port, manual_automatic_key, shed_seconds} = 10'h000;
      slave_address = $urandom_range(1, 247);
      option_bits = $urandom;
      summary_value = $urandom;
      input1_value = $urandom;
      input2_value = $urandom;
      repeat (10) @(posedge clk);
      #1 resetn = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      foreach (DT[i]) begin
         d = $urandom;
         h = hits;
         xfer(wr(DT[i], d), wr(DT[i], d), 1'h0);
         chk(hits, h + 1);
         chk(ntag, DT[i]);
         chk(ndat, d);
         chk(monitor_mode, 1'h1);
      end
      shed_seconds = 8'h01;
      d = $urandom;
      xfer(wr(ANALOG_HI, d), wr(ANALOG_HI, d), 1'h0);
      chk(host.t0 > done_t, 1'h1);
      chk(slave_mode, 1'h1);
      foreach (RO[i]) xfer(wr(RO[i], $urandom), ex(FN_WRITE, EX_ADDR), 1'h0);
      // two floats' worth of registers, then the same cut short
      q = wr(DIGITAL_LO, d);
      q[9] = 8'h04;
      xfer(q, ex(FN_WRITE, EX_DATA), 1'h0);
      void'(q.pop_back());
      xfer(q, ex(FN_WRITE, EX_DATA), 1'h0);
      xfer(rd(TAG_OPTIONS), rr({24'h000000, option_bits}), 1'h0);
      xfer(rd(TAG_REV), rr({16'h0000, REV}), 1'h0);
      xfer(rd(TAG_IN1), rr(input1_value), 1'h0);
      d = $urandom;
      h = hits;
      xfer(wr(TAG_OVERRIDE, d), wr(TAG_OVERRIDE, d), 1'h0);
      chk(hits, h);
      chk(override_value, d);
      chk(override_active, 1'h1);
      xfer(wr(TAG_OVERRIDE, ~d), '{}, 1'h1);
      chk(override_value, d);
      foreach (WF[i]) begin
         host.send('{slave_address, WF[i]}, 1'h0);
         repeat (20 * MS) @(posedge clk);
         chk(lfn, WF[i]);
      end
      xfer('{slave_address, 8'h05}, ex(8'h05, EX_FUNC), 1'h0);
      ir_port = 1'h1;
      xfer('{slave_address, 8'h03}, ex(8'h03, EX_FUNC), 1'h0);
      xfer(rd(TAG_IN2), rr(input2_value), 1'h0);
      ir_port = 1'h0;
      h = sheds;
      for (int k = 0; k < 6000 && sheds == h; k++) @(posedge clk);
      chk(sheds, h + 1);
      chk(slave_mode, 1'h0);
      chk(override_active, 1'h0);
      #1 xfer(wr(TAG_OVERRIDE, d), wr(TAG_OVERRIDE, d), 1'h0);
      chk(slave_mode, 1'h1);
      manual_automatic_key = 1'h1;
      @(posedge clk);
      #1 manual_automatic_key = 1'h0;
      repeat (2) @(posedge clk);
      chk(emergency_manual, 1'h1);
      chk(slave_mode, 1'h0);
      print_verdict();
   end
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule // tb_top
